// ===== core/mcg_pkg.sv
package mcg_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int ACC_W  = 24;

  // Accumulator moduli; the scaled one makes the conversion, symbol and non-exempt bit clocks 8/7 faster.
  localparam logic [ACC_W-1:0] MOD_NORM   = ACC_W'(CLK_HZ);
  localparam logic [ACC_W-1:0] MOD_SCALED = ACC_W'(CLK_HZ * 7 / 8);
  localparam logic [ACC_W-1:0] REF_HALF   = ACC_W'(CLK_HZ / 2);

  // Sample, bit and symbol rates in Hz.
  localparam int RATE_9600  = 9600;
  localparam int RATE_8000  = 8000;
  localparam int RATE_7200  = 7200;
  localparam int BIT_RATE_0 = 19200;
  localparam int BIT_RATE_1 = 9600;
  localparam int BIT_RATE_2 = 7200;
  localparam int BIT_RATE_3 = 4800;
  localparam int BIT_RATE_4 = 2400;
  localparam int BIT_RATE_5 = 1200;
  localparam int BIT_RATE_6 = 600;
  localparam int BIT_RATE_7 = 300;
  localparam int SYM_RATE_0 = 2400;
  localparam int SYM_RATE_1 = 1600;
  localparam int SYM_RATE_2 = 1200;
  localparam int SYM_RATE_3 = 600;

  localparam logic [2:0] BIT_SEL_EXEMPT = 3'h0;
  localparam logic [1:0] RATE_SEL_9600  = 2'h0;
  localparam logic [1:0] RATE_SEL_8000  = 2'h1;

  // Operating mode codes.
  localparam logic [2:0] MODE_FALLBACK = 3'h0;
  localparam logic [2:0] MODE_V32_SYNC = 3'h4;
  localparam logic [2:0] MODE_V32_INT  = 3'h5;
  localparam logic [2:0] MODE_LOOP     = 3'h6;
  localparam logic [2:0] MODE_ASYNC_TS = 3'h7;

  // Conversion step per master cycle; strobe once per sample period.
  function automatic logic [ACC_W-1:0] conv_inc(input logic [1:0] sel);
    case (sel)
      RATE_SEL_9600: conv_inc = ACC_W'(RATE_9600);
      RATE_SEL_8000: conv_inc = ACC_W'(RATE_8000);
      default:       conv_inc = ACC_W'(RATE_7200);
    endcase
  endfunction

  // Bit clock step; twice the rate because the output toggles on each wrap.
  function automatic logic [ACC_W-1:0] bit_inc(input logic [2:0] sel);
    int r;
    case (sel)
      3'h0:    r = BIT_RATE_0;
      3'h1:    r = BIT_RATE_1;
      3'h2:    r = BIT_RATE_2;
      3'h3:    r = BIT_RATE_3;
      3'h4:    r = BIT_RATE_4;
      3'h5:    r = BIT_RATE_5;
      3'h6:    r = BIT_RATE_6;
      default: r = BIT_RATE_7;
    endcase
    bit_inc = ACC_W'(2 * r);
  endfunction

  // Symbol clock step, twice the rate for the same reason.
  function automatic logic [ACC_W-1:0] sym_inc(input logic [1:0] sel);
    int r;
    case (sel)
      2'h0:    r = SYM_RATE_0;
      2'h1:    r = SYM_RATE_1;
      2'h2:    r = SYM_RATE_2;
      default: r = SYM_RATE_3;
    endcase
    sym_inc = ACC_W'(2 * r);
  endfunction

  // True for the synchronous family of modes.
  function automatic logic is_v32(input logic [2:0] m);
    is_v32 = (m == MODE_V32_SYNC) || (m == MODE_V32_INT) || (m == MODE_LOOP);
  endfunction

endpackage

// ===== core/mcg_clock_gen.sv
`timescale 1ns/1ps
module mcg_clock_gen #(
  parameter int PHASE_W = 9,
  parameter int DATA_W  = 16
) (
  input  wire logic                      I_REF_CLK,
  input  wire logic                      I_RESET_N,
  input  wire logic [2:0]                I_OPERATING_MODE_FIELD,
  input  wire logic                      I_HIGH_SPEED,
  input  wire logic [1:0]                I_SAMPLE_RATE_SEL,
  input  wire logic [2:0]                I_SYNC_RATE_SEL,
  input  wire logic                      I_INTERP_EN,
  input  wire logic [2:0]                I_TX_BIT_SEL,
  input  wire logic [1:0]                I_TX_SYM_SEL,
  input  wire logic [2:0]                I_RX_BIT_SEL,
  input  wire logic [1:0]                I_RX_SYM_SEL,
  input  wire logic signed [PHASE_W-1:0] I_RX_PHASE,
  input  wire logic                      I_RX_PHASE_WR,
  input  wire logic signed [PHASE_W-1:0] I_TX_PHASE,
  input  wire logic                      I_TX_PHASE_WR,
  input  wire logic                      I_TERMINAL_SYNC_IN,
  input  wire logic [DATA_W-1:0]         I_TX_SAMPLE,
  input  wire logic [DATA_W-1:0]         I_ADC_RESULT,
  input  wire logic [DATA_W-1:0]         I_INTERP_IN,
  output logic                           O_TX_CONVERT_STROBE,
  output logic                           O_RX_CONVERT_STROBE,
  output logic                           O_TX_BIT_CLOCK,
  output logic                           O_TX_SYMBOL_CLOCK,
  output logic                           O_RX_BIT_CLOCK,
  output logic                           O_RX_SYMBOL_CLOCK,
  output logic                           O_DAC_UPDATE,
  output logic [DATA_W-1:0]              O_DAC_SAMPLE,
  output logic [DATA_W-1:0]              O_RX_SAMPLE,
  output logic                           O_INTERP_LOAD,
  output logic                           O_INTERP_OUT_STROBE,
  output logic [DATA_W-1:0]              O_INTERP_OUT,
  output logic                           O_SOFT_RESET,
  output logic                           O_LOCK_DONE
);

  localparam int AW = mcg_pkg::ACC_W;
  localparam int NCO_N = 7;
  localparam int TXC = 0;
  localparam int TXB = 1;
  localparam int TXS = 2;
  localparam int RXC = 3;
  localparam int RXB = 4;
  localparam int RXS = 5;
  localparam int REF = 6;

  typedef enum logic [2:0] {
    ST_SRST = 3'b001,
    ST_LOCK = 3'b010,
    ST_RUN  = 3'b100
  } mcg_state_e;

  // One accumulator step of k increments, reporting a wrap in the top bit.
  function automatic logic [AW:0] nco_step(input logic [AW-1:0] a, input logic [AW-1:0] inc,
                                           input logic [AW-1:0] md, input logic [1:0] k);
    logic [AW:0] s;
    s = {1'b0, a};
    if (k == 2'h2) begin
      s = s + {inc, 1'b0};
    end else if (k == 2'h1) begin
      s = s + {1'b0, inc};
    end
    if (s >= {1'b0, md}) begin
      nco_step = {1'b1, AW'(s - {1'b0, md})};
    end else begin
      nco_step = {1'b0, s[AW-1:0]};
    end
  endfunction

  mcg_state_e                 state_reg, state_next;
  logic [2:0]                 mode_reg, mode_next;
  logic [1:0]                 rate_reg, rate_next;
  logic [2:0]                 sync_reg, sync_next;
  logic                       scale_reg, scale_next;
  logic                       terminal_sync_in_reg, terminal_sync_in_next;
  logic signed [PHASE_W-1:0]  tx_adj_reg, tx_adj_next;
  logic signed [PHASE_W-1:0]  rx_adj_reg, rx_adj_next;
  logic [AW-1:0]              acc_reg [0:NCO_N-1];
  logic [AW-1:0]              acc_next [0:NCO_N-1];
  logic [AW-1:0]              inc [0:NCO_N-1];
  logic [AW-1:0]              modv [0:NCO_N-1];
  logic [1:0]                 kv [0:NCO_N-1];
  logic [NCO_N-1:0]           wrap;
  logic                       srst_req, mode_chg, lock_evt, run, digital_phase_lock_loop_fire;
  logic                       rx_first, scaled;
  logic [AW-1:0]              mod_c;
  logic                       txc_reg, rxc_reg, txb_reg, txs_reg, rxb_reg, rxs_reg;
  logic                       txc_next, rxc_next, txb_next, txs_next, rxb_next, rxs_next;
  logic                       dac_up_reg, dac_up_next, ild_reg, ild_next, iout_reg, iout_next;
  logic                       srst_out_reg, lock_reg;
  logic [DATA_W-1:0]          dac_reg, dac_next, adc_reg, adc_next;
  logic [DATA_W-1:0]          ihold_reg, ihold_next, iout_d_reg, iout_d_next;

  // Configuration tracking, soft reset detection and the lock sequence.
  always_comb begin
    mode_next  = I_OPERATING_MODE_FIELD;
    rate_next  = I_SAMPLE_RATE_SEL;
    sync_next  = I_SYNC_RATE_SEL;
    scale_next = I_HIGH_SPEED;
    mode_chg   = (I_OPERATING_MODE_FIELD != mode_reg);
    srst_req   = (mcg_pkg::is_v32(I_OPERATING_MODE_FIELD) && !mcg_pkg::is_v32(mode_reg))
                 || (rate_next != rate_reg) || (sync_next != sync_reg)
                 || (scale_next != scale_reg);
    rx_first   = (mode_reg == mcg_pkg::MODE_V32_SYNC) || (mode_reg == mcg_pkg::MODE_V32_INT);
    // Receive locks to transmit first; loopback locks transmit to receive.
    if (rx_first) begin
      lock_evt = wrap[TXC];
    end else if (mode_reg == mcg_pkg::MODE_LOOP) begin
      lock_evt = wrap[RXC];
    end else begin
      lock_evt = 1'b1;
    end
    state_next = state_reg;
    case (state_reg)
      ST_SRST: state_next = ST_LOCK;
      ST_LOCK: begin
        if (lock_evt) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN:  state_next = ST_RUN;
      default: state_next = ST_SRST;
    endcase
    if (srst_req) begin
      state_next = ST_SRST;
    end else if (mode_chg) begin
      state_next = ST_LOCK;
    end
  end

  // Phase adjustment: pending cycles stretch or shorten the path's periods.
  always_comb begin
    run        = (state_reg == ST_RUN);
    terminal_sync_in_next = I_TERMINAL_SYNC_IN;
    tx_adj_next = tx_adj_reg;
    rx_adj_next = rx_adj_reg;
    if (tx_adj_reg > 0) tx_adj_next = tx_adj_reg - PHASE_W'(1);
    if (tx_adj_reg < 0) tx_adj_next = tx_adj_reg + PHASE_W'(1);
    if (rx_adj_reg > 0) rx_adj_next = rx_adj_reg - PHASE_W'(1);
    if (rx_adj_reg < 0) rx_adj_next = rx_adj_reg + PHASE_W'(1);
    if (run && I_RX_PHASE_WR) begin
      rx_adj_next = I_RX_PHASE;
      if (mode_reg == mcg_pkg::MODE_LOOP) begin
        tx_adj_next = I_RX_PHASE;
      end
    end
    if (run && I_TX_PHASE_WR && ((mode_reg == mcg_pkg::MODE_FALLBACK)
                                 || (mode_reg == mcg_pkg::MODE_V32_INT))) begin
      tx_adj_next = I_TX_PHASE;
    end
    // Bang-bang loop: in run in MODE_V32_SYNC or MODE_ASYNC_TS, each rising terminal sync edge with no transmit adjustment pending nudges transmit one cycle.
    digital_phase_lock_loop_fire = run && I_TERMINAL_SYNC_IN && !terminal_sync_in_reg && (tx_adj_reg == 0)
                && ((mode_reg == mcg_pkg::MODE_V32_SYNC)
                    || (mode_reg == mcg_pkg::MODE_ASYNC_TS));
    if (digital_phase_lock_loop_fire) begin
      tx_adj_next = (acc_reg[REF] < mcg_pkg::REF_HALF) ? -PHASE_W'(1) : PHASE_W'(1);
      if ((mode_reg == mcg_pkg::MODE_V32_SYNC) && (rx_adj_reg == 0)) begin
        rx_adj_next = tx_adj_next;
      end
    end
    if (state_reg == ST_SRST) begin
      tx_adj_next = '0;
      rx_adj_next = '0;
    end
  end

  // Rate generators, all stepped from the one master clock.
  always_comb begin
    scaled = scale_reg && ((mode_reg == mcg_pkg::MODE_V32_SYNC)
                           || (mode_reg == mcg_pkg::MODE_V32_INT));
    mod_c  = scaled ? mcg_pkg::MOD_SCALED : mcg_pkg::MOD_NORM;
    inc[TXC] = mcg_pkg::conv_inc(rate_reg);
    inc[RXC] = mcg_pkg::conv_inc(rate_reg);
    inc[TXB] = mcg_pkg::bit_inc(I_TX_BIT_SEL);
    inc[RXB] = mcg_pkg::bit_inc(I_RX_BIT_SEL);
    inc[TXS] = mcg_pkg::sym_inc(I_TX_SYM_SEL);
    inc[RXS] = mcg_pkg::sym_inc(I_RX_SYM_SEL);
    inc[REF] = mcg_pkg::bit_inc(sync_reg);
    modv[TXC] = mod_c;
    modv[RXC] = mod_c;
    modv[TXS] = mod_c;
    modv[RXS] = mod_c;
    modv[TXB] = (I_TX_BIT_SEL == mcg_pkg::BIT_SEL_EXEMPT) ? mcg_pkg::MOD_NORM : mod_c;
    modv[RXB] = (I_RX_BIT_SEL == mcg_pkg::BIT_SEL_EXEMPT) ? mcg_pkg::MOD_NORM : mod_c;
    modv[REF] = mcg_pkg::MOD_NORM;
    for (int i = 0; i < NCO_N; i++) begin
      if (state_reg == ST_SRST) begin
        kv[i] = 2'h0;
      end else if (i < RXC || i == REF) begin
        kv[i] = (tx_adj_reg > 0) ? 2'h2 : (tx_adj_reg < 0) ? 2'h0 : 2'h1;
      end else begin
        kv[i] = (rx_adj_reg > 0) ? 2'h2 : (rx_adj_reg < 0) ? 2'h0 : 2'h1;
      end
      {wrap[i], acc_next[i]} = nco_step(acc_reg[i], inc[i], modv[i], kv[i]);
      if (state_reg == ST_SRST) begin
        acc_next[i] = '0;
      end
    end
    // Initial lock copies the leading path's phase into the following path.
    if (state_reg == ST_LOCK && lock_evt && rx_first) begin
      acc_next[RXC] = acc_next[TXC];
      acc_next[RXB] = '0;
      acc_next[RXS] = '0;
    end
    if (state_reg == ST_LOCK && lock_evt && mode_reg == mcg_pkg::MODE_LOOP) begin
      acc_next[TXC] = acc_next[RXC];
      acc_next[TXB] = '0;
      acc_next[TXS] = '0;
    end
  end

  // Strobes, clock levels and sample transfers.
  always_comb begin
    txc_next = wrap[TXC];
    rxc_next = wrap[RXC];
    txb_next = txb_reg ^ wrap[TXB];
    txs_next = txs_reg ^ wrap[TXS];
    rxb_next = rxb_reg ^ wrap[RXB];
    rxs_next = rxs_reg ^ wrap[RXS];
    dac_next = dac_reg;
    adc_next = adc_reg;
    ihold_next  = ihold_reg;
    iout_d_next = iout_d_reg;
    // Loopback runs the converters from the receive strobe.
    if (mode_reg == mcg_pkg::MODE_LOOP) begin
      dac_up_next = wrap[RXC];
    end else begin
      dac_up_next = wrap[TXC];
    end
    if (dac_up_next) begin
      dac_next = I_TX_SAMPLE;
    end
    if (mcg_pkg::is_v32(mode_reg) ? dac_up_next : wrap[RXC]) begin
      adc_next = I_ADC_RESULT;
    end
    ild_next  = I_INTERP_EN && rx_first && wrap[TXC];
    iout_next = I_INTERP_EN && rx_first && wrap[RXC];
    if (ild_next) begin
      ihold_next = I_INTERP_IN;
    end
    if (iout_next) begin
      iout_d_next = ild_next ? I_INTERP_IN : ihold_reg;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_reg    <= ST_SRST;
      mode_reg     <= mcg_pkg::MODE_FALLBACK;
      rate_reg     <= mcg_pkg::RATE_SEL_9600;
      sync_reg     <= 3'h0;
      scale_reg    <= 1'b0;
      terminal_sync_in_reg    <= 1'b0;
      tx_adj_reg   <= '0;
      rx_adj_reg   <= '0;
      for (int i = 0; i < NCO_N; i++) acc_reg[i] <= '0;
      {txc_reg, rxc_reg, txb_reg, txs_reg, rxb_reg, rxs_reg} <= 6'h00;
      {dac_up_reg, ild_reg, iout_reg, srst_out_reg, lock_reg} <= 5'h00;
      dac_reg      <= '0;
      adc_reg      <= '0;
      ihold_reg    <= '0;
      iout_d_reg   <= '0;
    end else begin
      state_reg    <= state_next;
      mode_reg     <= mode_next;
      rate_reg     <= rate_next;
      sync_reg     <= sync_next;
      scale_reg    <= scale_next;
      terminal_sync_in_reg    <= terminal_sync_in_next;
      tx_adj_reg   <= tx_adj_next;
      rx_adj_reg   <= rx_adj_next;
      for (int i = 0; i < NCO_N; i++) acc_reg[i] <= acc_next[i];
      {txc_reg, rxc_reg, txb_reg, txs_reg, rxb_reg, rxs_reg} <=
        {txc_next, rxc_next, txb_next, txs_next, rxb_next, rxs_next};
      {dac_up_reg, ild_reg, iout_reg} <= {dac_up_next, ild_next, iout_next};
      srst_out_reg <= (state_next == ST_SRST);
      lock_reg     <= (state_next == ST_RUN);
      dac_reg      <= dac_next;
      adc_reg      <= adc_next;
      ihold_reg    <= ihold_next;
      iout_d_reg   <= iout_d_next;
    end
  end

  // Every output is taken straight from a flip-flop.
  assign O_TX_CONVERT_STROBE = txc_reg;
  assign O_RX_CONVERT_STROBE = rxc_reg;
  assign O_TX_BIT_CLOCK      = txb_reg;
  assign O_TX_SYMBOL_CLOCK   = txs_reg;
  assign O_RX_BIT_CLOCK      = rxb_reg;
  assign O_RX_SYMBOL_CLOCK   = rxs_reg;
  assign O_DAC_UPDATE        = dac_up_reg;
  assign O_DAC_SAMPLE        = dac_reg;
  assign O_RX_SAMPLE         = adc_reg;
  assign O_INTERP_LOAD       = ild_reg;
  assign O_INTERP_OUT_STROBE = iout_reg;
  assign O_INTERP_OUT        = iout_d_reg;
  assign O_SOFT_RESET        = srst_out_reg;
  assign O_LOCK_DONE         = lock_reg;

  // Checks on the generated timing and the mode behaviour.
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);

  AST_TX_STROBE_LOADS: assert property (
    (wrap[TXC] && rx_first) |=> (O_TX_CONVERT_STROBE && O_DAC_UPDATE
      && O_DAC_SAMPLE == $past(I_TX_SAMPLE) && O_RX_SAMPLE == $past(I_ADC_RESULT)))
    else $error("Transmit strobe did not load the samples.");
  AST_INTERP_GATE: assert property (
    O_INTERP_LOAD |-> ($past(I_INTERP_EN) && O_TX_CONVERT_STROBE))
    else $error("Interpolator loaded while disabled.");
  AST_INTERP_RATE: assert property (
    O_INTERP_OUT_STROBE |-> (O_RX_CONVERT_STROBE && $past(rx_first)))
    else $error("Interpolator output off the receive strobe.");
  AST_LOCK_ORDER: assert property (
    (state_reg == ST_LOCK && rx_first && wrap[TXC] && !srst_req && !mode_chg)
      |=> (acc_reg[RXC] == acc_reg[TXC]) && (state_reg == ST_RUN))
    else $error("Receive conversion not aligned before run.");
  AST_NO_LOOP_BEFORE_LOCK: assert property (
    (state_reg != ST_RUN) |-> !digital_phase_lock_loop_fire)
    else $error("Phase loop acted before initial lock.");
  AST_SOFT_RESET_ENTRY: assert property (
    (!mcg_pkg::is_v32(mode_reg) && mcg_pkg::is_v32(I_OPERATING_MODE_FIELD))
      |=> O_SOFT_RESET ##1 (state_reg == ST_LOCK || O_SOFT_RESET))
    else $error("No soft reset on entering the synchronous family.");
  AST_RX_REWRITE: assert property (
    (run && I_RX_PHASE_WR && mode_reg == mcg_pkg::MODE_V32_INT)
      |=> (rx_adj_reg == $past(I_RX_PHASE)))
    else $error("Receive phase write not applied.");
  AST_LOOP_SHIFT: assert property (
    (run && I_RX_PHASE_WR && mode_reg == mcg_pkg::MODE_LOOP)
      |=> (tx_adj_reg == rx_adj_reg))
    else $error("Loopback transmit phase did not follow receive.");
  AST_FALLBACK_IDLE: assert property (
    (mode_reg == mcg_pkg::MODE_FALLBACK) |-> !digital_phase_lock_loop_fire)
    else $error("Phase loop active in fallback mode.");
  AST_SCALE: assert property (
    (scaled && kv[TXC] == 2'h1) |-> (mod_c == mcg_pkg::MOD_SCALED))
    else $error("Scaled mode not using scaled modulus.");

  // Cycles since the last interpolator load; saturates so a long gap never wraps.
  logic [11:0] ld_gap_reg, ld_gap_next;
  always_comb begin
    ld_gap_next = (ld_gap_reg == 12'hfff) ? ld_gap_reg : ld_gap_reg + 12'h001;
    if (O_INTERP_LOAD) begin
      ld_gap_next = 12'h000;
    end
  end

  // Registers the load distance counter.
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ld_gap_reg <= 12'hfff;
    end else begin
      ld_gap_reg <= ld_gap_next;
    end
  end

  COV_SOFT_RESET: cover property (O_SOFT_RESET ##1 !O_SOFT_RESET);
  COV_LOCK: cover property ($rose(O_LOCK_DONE) && rx_first);
  COV_INTERP: cover property (O_INTERP_OUT_STROBE && (ld_gap_reg < 12'h7d0));
  COV_DIGITAL_PHASE_LOCK_LOOP: cover property (digital_phase_lock_loop_fire);

endmodule

// ===== test/mcg_sync_model.sv
`timescale 1ns/1ps
// Terminal sync source at the rate the host has programmed.
module mcg_sync_model #(
  parameter int PERIOD = 2083
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      sync_out
);
  int cnt;
  // Square wave; each rising edge marks one sync period.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      sync_out <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sync_out <= (cnt < PERIOD / 2);
    end
  end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, s); end end
module tb_top;
  logic clk, rst_n, hs, ien, rwr, twr, terminal_sync_in, tcs, tbc, srst, lck, il;
  logic rcs, du, io, rbc, tsc, rsc;
  logic [2:0] mode, ssel, tbs, rbs;
  logic [1:0] srate, tss, rss;
  logic signed [8:0] ph;
  logic [15:0] txs, adc, iin, dac, rxs, iout;
  int fail_count, cmp_count, cyc, n, p, k;
  logic [31:0] rs;
  logic [2:0] ml[7] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h5, 3'h0};
  int rt[3] = '{mcg_pkg::RATE_9600, mcg_pkg::RATE_8000, mcg_pkg::RATE_7200};
  mcg_sync_model #(.PERIOD(2083)) SYNC (.clk(clk), .rst_n(rst_n), .sync_out(terminal_sync_in));
  mcg_clock_gen DUT (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_OPERATING_MODE_FIELD(mode),
    .I_HIGH_SPEED(hs), .I_SAMPLE_RATE_SEL(srate), .I_SYNC_RATE_SEL(ssel), .I_INTERP_EN(ien),
    .I_TX_BIT_SEL(tbs), .I_TX_SYM_SEL(tss), .I_RX_BIT_SEL(rbs), .I_RX_SYM_SEL(rss),
    .I_RX_PHASE(ph), .I_RX_PHASE_WR(rwr), .I_TX_PHASE(ph), .I_TX_PHASE_WR(twr),
    .I_TERMINAL_SYNC_IN(terminal_sync_in), .I_TX_SAMPLE(txs), .I_ADC_RESULT(adc), .I_INTERP_IN(iin),
    .O_TX_CONVERT_STROBE(tcs), .O_RX_CONVERT_STROBE(rcs), .O_TX_BIT_CLOCK(tbc),
    .O_TX_SYMBOL_CLOCK(tsc), .O_RX_BIT_CLOCK(rbc), .O_RX_SYMBOL_CLOCK(rsc),
    .O_DAC_UPDATE(du), .O_DAC_SAMPLE(dac), .O_RX_SAMPLE(rxs), .O_INTERP_LOAD(il),
    .O_INTERP_OUT_STROBE(io),
    .O_INTERP_OUT(iout), .O_SOFT_RESET(srst), .O_LOCK_DONE(lck));
  // Xorshift source for repeatable random stimulus.
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // Period in master cycles of one event at the given rate.
  function automatic int per(input int hz, input bit sc);
    return (sc ? 8750000 : 10000000) / hz;
  endfunction
  // Bit and symbol rates in Hz for the selects that the bench uses.
  function automatic int bit_hz(input logic [2:0] s);
    case (s)
      3'h0: return mcg_pkg::BIT_RATE_0;
      3'h1: return mcg_pkg::BIT_RATE_1;
      3'h2: return mcg_pkg::BIT_RATE_2;
      default: return mcg_pkg::BIT_RATE_3;
    endcase
  endfunction
  function automatic int sym_hz(input logic [1:0] s);
    return (s == 2'h0) ? mcg_pkg::SYM_RATE_0 : mcg_pkg::SYM_RATE_1;
  endfunction
  // True for the modes whose entry from outside must soft reset.
  function automatic bit fam(input logic [2:0] m);
    return m == mcg_pkg::MODE_V32_SYNC || m == mcg_pkg::MODE_V32_INT
      || m == mcg_pkg::MODE_LOOP;
  endfunction
  // Level of a watched output: 0 tx strobe, 1 tx bit, 2 rx strobe, 3 rx bit, 4 and 5 symbols.
  function automatic logic sg(input int w);
    case (w)
      0: return tcs;
      1: return tbc;
      2: return rcs;
      3: return rbc;
      4: return tsc;
      default: return rsc;
    endcase
  endfunction
  // Cycles to the next strobe, or to the next edge of a clock output.
  task automatic gap(input int w, output int c);
    logic q;
    c = 0;
    q = sg(w);
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (!((w == 0 || w == 2) ? (sg(w) === 1'b1) : (sg(w) !== q)) && c < 20000);
  endtask
  // The phase loop may stretch or shorten one period by a cycle, so j widens by one.
  task automatic chk_per(input int w, input int e, input int j, input string nm);
    gap(w, n);
    gap(w, n);
    `CHK(nm, 1'b1, (n >= e - j && n <= e + 1 + j))
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    {rst_n, hs, ien, rwr, twr, mode, ssel, tbs, rbs, srate, tss, rss, ph} = '0;
    {txs, adc, iin} = '0;
    rs = 32'h0569;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    ssel <= 3'h3;
    for (int r = 0; r < 3; r++) begin
      @(posedge clk);
      srate <= 2'(r);
      chk_per(0, per(rt[r], 1'b0), 0, "tx strobe period");
    end
    @(posedge clk);
    srate <= 2'h0;
    for (int i = 1; i < 7; i++) begin
      @(posedge clk);
      mode <= ml[i];
      k = 0;
      repeat (3) begin
        @(posedge clk);
        #1;
        k |= (srst === 1'b1);
      end
      `CHK("soft reset", fam(ml[i]) && !fam(ml[i-1]), k)
      gap(0, n);
      for (int w = 0; w < 1100 && lck !== 1'b1; w++) begin
        @(posedge clk);
        #1;
      end
      `CHK("lock done", 1'b1, lck)
      p = (ml[i] == mcg_pkg::MODE_V32_SYNC || ml[i] == mcg_pkg::MODE_ASYNC_TS);
      chk_per(0, per(rt[0], 1'b0), p, "mode strobe period");
    end
    $display("test modes done");
    @(posedge clk);
    mode <= mcg_pkg::MODE_V32_INT;
    ien <= 1'b1;
    repeat (3) begin
      @(posedge clk);
      rs = xs(rs);
      txs <= rs[15:0];
      adc <= rs[31:16];
      iin <= rs[23:8];
      gap(0, n);
      gap(0, n);
      `CHK("dac update", 1'b1, du)
      `CHK("rx strobe", 1'b1, rcs)
      `CHK("interp strobe", 1'b1, io)
      repeat (2) @(posedge clk);
      #1;
      `CHK("dac sample", txs, dac)
      `CHK("rx sample", adc, rxs)
      `CHK("interp out", iin, iout)
    end
    @(posedge clk);
    ien <= 1'b0;
    k = 0;
    repeat (2200) begin
      @(posedge clk);
      #1;
      k |= (il === 1'b1);
    end
    `CHK("interp load off", 0, k)
    $display("test data done");
    @(posedge clk);
    hs <= 1'b1;
    chk_per(0, per(rt[0], 1'b1), 0, "scaled strobe");
    @(posedge clk);
    rs = xs(rs);
    tbs <= 3'(rs[1:0]);
    rbs <= 3'(rs[3:2]);
    tss <= {1'b0, rs[4]};
    rss <= {1'b0, rs[5]};
    chk_per(1, per(2 * bit_hz(3'(rs[1:0])), rs[1:0] != 2'h0), 0, "tx bit half");
    chk_per(3, per(2 * bit_hz(3'(rs[3:2])), rs[3:2] != 2'h0), 0, "rx bit half");
    chk_per(4, per(2 * sym_hz({1'b0, rs[4]}), 1'b1), 0, "tx symbol half");
    chk_per(5, per(2 * sym_hz({1'b0, rs[5]}), 1'b1), 0, "rx symbol half");
    $display("test scaling done");
    // Receive advance, then transmit retard, both small enough for the scaled mode.
    gap(0, n);
    @(posedge clk);
    ph <= 9'h005;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
    gap(2, n);
    gap(0, n);
    `CHK("rx phase lead", 5, n)
    @(posedge clk);
    ph <= 9'h1fd;
    twr <= 1'b1;
    @(posedge clk);
    twr <= 1'b0;
    gap(2, n);
    gap(0, n);
    `CHK("tx phase retard", 8, n)
    // Loopback: a receive adjustment must carry the transmit strobe along.
    @(posedge clk);
    mode <= mcg_pkg::MODE_LOOP;
    gap(2, n);
    @(posedge clk);
    ph <= 9'h004;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
    gap(2, n);
    `CHK("loop tx follows rx", 1'b1, tcs)
    `CHK("loop dac update", 1'b1, du)
    $display("test phase done");
    complete_run();
  end
endmodule
